//--- core/hss_pkg.sv
// Package with register map, reset values, limits, modes and carrier types of the homing sequencer
package hss_pkg;

  // ----------------------------------------------------------------
  // Register offsets (parameter addresses)
  // ----------------------------------------------------------------
  localparam logic [15:0] HOME_SWITCH_POLARITY_ADDR = 16'h061C;
  localparam logic [15:0] NEGATIVE_LIMIT_POLARITY_ADDR = 16'h061E;
  localparam logic [15:0] POSITIVE_LIMIT_POLARITY_ADDR = 16'h0620;
  localparam logic [15:0] SWITCH_SEARCH_SPEED_ADDR = 16'h2808;
  localparam logic [15:0] SWITCH_LEAVE_SPEED_ADDR = 16'h280A;
  localparam logic [15:0] EDGE_SEARCH_LIMIT_ADDR = 16'h280C;
  localparam logic [15:0] EDGE_TO_HOME_DISTANCE_ADDR = 16'h280E;
  localparam logic [15:0] HOME_POSITION_VALUE_ADDR = 16'h2816;
  localparam logic [15:0] OVERRUN_SEARCH_LIMIT_ADDR = 16'h281A;
  localparam logic [15:0] HOMING_METHOD_SELECT_ADDR = 16'h2800;

  // ----------------------------------------------------------------
  // Reset values and ranges
  // ----------------------------------------------------------------
  localparam logic [15:0] POLARITY_RESET = 16'h0001;
  localparam logic [15:0] POL_INACTIVE = 16'h0000;
  localparam logic [15:0] POL_NC = 16'h0001;
  localparam logic [15:0] POL_NO = 16'h0002;
  localparam logic [15:0] SEARCH_SPEED_RESET = 16'h003C;
  localparam logic [15:0] SEARCH_SPEED_MAX = 16'h3390;
  localparam logic [15:0] LEAVE_SPEED_RESET = 16'h0006;
  localparam logic [15:0] LEAVE_SPEED_MAX = 16'h0BB8;
  localparam logic [15:0] SPEED_MIN = 16'h0001;
  localparam logic [31:0] EDGE_SEARCH_RESET = 32'h0000_0000;
  localparam logic [31:0] EDGE_DIST_RESET = 32'h0000_00C8;
  localparam logic [31:0] EDGE_DIST_MIN = 32'h0000_0001;
  localparam logic [31:0] HOME_POS_RESET = 32'h0000_0000;
  localparam logic [31:0] OVERRUN_RESET = 32'h0000_0000;
  localparam logic [15:0] METHOD_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Homing method codes handled here
  // ----------------------------------------------------------------
  localparam logic [15:0] METHOD_NEG_LIMIT = 16'h0011;
  localparam logic [15:0] METHOD_HOME_FIRST = 16'h001B;
  localparam logic [15:0] METHOD_HOME_LAST = 16'h001E;

  // ----------------------------------------------------------------
  // Sequencer states and carriers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_SEARCH = 3'b001,
    HS_OVERRUN = 3'b010,
    HS_EDGE = 3'b011,
    HS_DIST = 3'b100,
    HS_LOAD = 3'b101
  } hss_state_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } hss_reg_req_t;

  typedef struct packed {
    logic valid;
    logic err;
    logic [31:0] rdata;
  } hss_reg_rsp_t;

  typedef struct packed {
    logic move;
    logic dirPos;
    logic [15:0] speed;
  } hss_motion_t;

endpackage : hss_pkg

//--- core/hss_switch_eval.sv
// Evaluation of one switch input according to its polarity setting
module hss_switch_eval (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Raw switch and setting
  input wire logic rawIn,
  input wire logic [15:0] polarity,
  input wire logic enable,
  // Evaluated level
  output logic active
);

  always_ff @(posedge clk) begin
    if (reset) begin
      active <= 1'b0;
    end else if (!enable) begin
      active <= 1'b0;
    end else begin
      case (polarity)
        hss_pkg::POL_NC: active <= !rawIn;
        hss_pkg::POL_NO: active <= rawIn;
        default: active <= 1'b0;
      endcase
    end
  end

endmodule : hss_switch_eval

//--- core/homing_switch_sequencer.sv
// Homing sequencer: switch search, edge search, distance move and zero point load
// Contract
// (RULE1) Home switch polarity 1 means normally closed, 2 means normally open.
// (RULE2) Home switch evaluated only while homing runs.
// (RULE3) Each limit switch: 0 disabled, 1 normally closed, 2 normally open.
// (RULE4) Search speed accepts 1 to 13200, default 60.
// (RULE5) Leave speed accepts 1 to 3000, default 6.
// (RULE6) Both speeds clamped to the ramp speed ceiling.
// (RULE7) On success load home position into motor position; default 0.
// (RULE8) Edge not found within nonzero edge search limit cancels with error.
// (RULE9) After overrun, switch must return within nonzero limit or cancel.
// (RULE10) Drive to switch, then to edge, then travel set distance.
// (RULE11) Edge to home distance 1 to max, default 200, non-index methods only.
// (RULE12) Approach at search speed; edge return and distance at leave speed.
// (RULE13) Method 17 homes on the negative travel switch.
// (RULE14) Methods 27 to 30 home on the home switch.
// (RULE15) Homing ends on success, halt or error; reference kept on disable.
// (RULE16) Zero point valid only after completion; restart needed; mode lock held.
// (RULE17) Separate done and error indications.
module homing_switch_sequencer (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Parameter access
  input wire hss_pkg::hss_reg_req_t regReq,
  output hss_pkg::hss_reg_rsp_t regRsp,
  // Switch inputs
  input wire logic homeSwitchIn,
  input wire logic negativeTravelSwitch,
  input wire logic positiveTravelSwitch,
  // Motion interface
  input wire logic [31:0] motorPosition,
  input wire logic [15:0] rampSpeedCeiling,
  input wire logic moveDone,
  input wire logic start,
  input wire logic halt,
  input wire logic powerEnabled,
  output hss_pkg::hss_motion_t motionCmd,
  output logic [31:0] distTarget,
  output logic distMoveReq,
  output logic posLoad,
  output logic [31:0] posLoadValue,
  // Status
  output logic busy,
  output logic done,
  output logic error,
  output logic refValid,
  output logic modeLock
);

  // ----------------------------------------------------------------
  // Parameter registers
  // ----------------------------------------------------------------
  logic [15:0] homePol_r;
  logic [15:0] negPol_r;
  logic [15:0] posPol_r;
  logic [15:0] searchSpeed_r;
  logic [15:0] leaveSpeed_r;
  logic [31:0] edgeLimit_r;
  logic [31:0] edgeDist_r;
  logic [31:0] homePos_r;
  logic [31:0] overrunLimit_r;
  logic [15:0] method_r;
  hss_pkg::hss_state_t state_r;
  hss_pkg::hss_state_t state_nxt;

  function automatic logic [15:0] clampSpeed(input logic [15:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < lo) begin
      return lo;
    end else if (v > hi) begin
      return hi;
    end
    return v;
  endfunction : clampSpeed

  function automatic logic [31:0] absDiff(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] d;
    d = a - b;
    return d[31] ? (32'h0000_0000 - d) : d;
  endfunction : absDiff

  function automatic logic overLimit(input logic [31:0] lim, input logic [31:0] trav);
    return (lim != 32'h0000_0000) && (trav > lim);
  endfunction : overLimit

  always_ff @(posedge clk) begin
    if (reset) begin
      homePol_r <= hss_pkg::POLARITY_RESET;
      negPol_r <= hss_pkg::POLARITY_RESET;
      posPol_r <= hss_pkg::POLARITY_RESET;
      searchSpeed_r <= hss_pkg::SEARCH_SPEED_RESET;
      leaveSpeed_r <= hss_pkg::LEAVE_SPEED_RESET;
      edgeLimit_r <= hss_pkg::EDGE_SEARCH_RESET;
      edgeDist_r <= hss_pkg::EDGE_DIST_RESET;
      homePos_r <= hss_pkg::HOME_POS_RESET;
      overrunLimit_r <= hss_pkg::OVERRUN_RESET;
      method_r <= hss_pkg::METHOD_RESET;
    end else if (regReq.wr) begin
      case (regReq.addr)
        hss_pkg::HOME_SWITCH_POLARITY_ADDR: begin
          if (regReq.wdata[15:0] == hss_pkg::POL_NC || regReq.wdata[15:0] == hss_pkg::POL_NO) begin
            homePol_r <= regReq.wdata[15:0]; // RULE1
          end
        end
        hss_pkg::NEGATIVE_LIMIT_POLARITY_ADDR: begin
          if (regReq.wdata[15:0] <= hss_pkg::POL_NO) begin
            negPol_r <= regReq.wdata[15:0]; // RULE3
          end
        end
        hss_pkg::POSITIVE_LIMIT_POLARITY_ADDR: begin
          if (regReq.wdata[15:0] <= hss_pkg::POL_NO) begin
            posPol_r <= regReq.wdata[15:0]; // RULE3
          end
        end
        hss_pkg::SWITCH_SEARCH_SPEED_ADDR: begin
          searchSpeed_r <= clampSpeed(regReq.wdata[15:0], hss_pkg::SPEED_MIN, hss_pkg::SEARCH_SPEED_MAX); // RULE4
        end
        hss_pkg::SWITCH_LEAVE_SPEED_ADDR: begin
          leaveSpeed_r <= clampSpeed(regReq.wdata[15:0], hss_pkg::SPEED_MIN, hss_pkg::LEAVE_SPEED_MAX); // RULE5
        end
        hss_pkg::EDGE_SEARCH_LIMIT_ADDR: begin
          if (!regReq.wdata[31]) begin
            edgeLimit_r <= regReq.wdata;
          end
        end
        hss_pkg::EDGE_TO_HOME_DISTANCE_ADDR: begin
          if (!regReq.wdata[31] && regReq.wdata >= hss_pkg::EDGE_DIST_MIN) begin
            edgeDist_r <= regReq.wdata; // RULE11
          end
        end
        hss_pkg::HOME_POSITION_VALUE_ADDR: begin
          homePos_r <= regReq.wdata;
        end
        hss_pkg::OVERRUN_SEARCH_LIMIT_ADDR: begin
          if (!regReq.wdata[31]) begin
            overrunLimit_r <= regReq.wdata;
          end
        end
        hss_pkg::HOMING_METHOD_SELECT_ADDR: begin
          // Method cannot change while a movement runs
          if (state_r == hss_pkg::HS_IDLE) begin
            method_r <= regReq.wdata[15:0];
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      regRsp <= '0;
    end else begin
      regRsp.valid <= regReq.rd || regReq.wr;
      regRsp.err <= 1'b0;
      regRsp.rdata <= 32'h0000_0000;
      if (regReq.rd) begin
        case (regReq.addr)
          hss_pkg::HOME_SWITCH_POLARITY_ADDR: regRsp.rdata <= {16'h0000, homePol_r};
          hss_pkg::NEGATIVE_LIMIT_POLARITY_ADDR: regRsp.rdata <= {16'h0000, negPol_r};
          hss_pkg::POSITIVE_LIMIT_POLARITY_ADDR: regRsp.rdata <= {16'h0000, posPol_r};
          hss_pkg::SWITCH_SEARCH_SPEED_ADDR: regRsp.rdata <= {16'h0000, searchSpeed_r};
          hss_pkg::SWITCH_LEAVE_SPEED_ADDR: regRsp.rdata <= {16'h0000, leaveSpeed_r};
          hss_pkg::EDGE_SEARCH_LIMIT_ADDR: regRsp.rdata <= edgeLimit_r;
          hss_pkg::EDGE_TO_HOME_DISTANCE_ADDR: regRsp.rdata <= edgeDist_r;
          hss_pkg::HOME_POSITION_VALUE_ADDR: regRsp.rdata <= homePos_r;
          hss_pkg::OVERRUN_SEARCH_LIMIT_ADDR: regRsp.rdata <= overrunLimit_r;
          hss_pkg::HOMING_METHOD_SELECT_ADDR: regRsp.rdata <= {13'h0000, state_r, method_r};
          default: regRsp.err <= 1'b1;
        endcase
      end else if (regReq.wr) begin
        case (regReq.addr)
          hss_pkg::HOME_SWITCH_POLARITY_ADDR, hss_pkg::NEGATIVE_LIMIT_POLARITY_ADDR,
          hss_pkg::POSITIVE_LIMIT_POLARITY_ADDR, hss_pkg::SWITCH_SEARCH_SPEED_ADDR,
          hss_pkg::SWITCH_LEAVE_SPEED_ADDR, hss_pkg::EDGE_SEARCH_LIMIT_ADDR,
          hss_pkg::EDGE_TO_HOME_DISTANCE_ADDR, hss_pkg::HOME_POSITION_VALUE_ADDR,
          hss_pkg::OVERRUN_SEARCH_LIMIT_ADDR, hss_pkg::HOMING_METHOD_SELECT_ADDR: regRsp.err <= 1'b0;
          default: regRsp.err <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Switch evaluation
  // ----------------------------------------------------------------
  logic homeActive;
  logic negActive;
  logic posActive;
  logic homingRun;
  assign homingRun = (state_r != hss_pkg::HS_IDLE);

  hss_switch_eval uHome (
    .clk(clk),
    .reset(reset),
    .rawIn(homeSwitchIn),
    .polarity(homePol_r),
    .enable(homingRun), // RULE2
    .active(homeActive)
  );

  hss_switch_eval uNeg (
    .clk(clk),
    .reset(reset),
    .rawIn(negativeTravelSwitch),
    .polarity(negPol_r),
    .enable(1'b1),
    .active(negActive)
  );

  hss_switch_eval uPos (
    .clk(clk),
    .reset(reset),
    .rawIn(positiveTravelSwitch),
    .polarity(posPol_r),
    .enable(1'b1),
    .active(posActive)
  );

  // ----------------------------------------------------------------
  // Method decode and targets
  // ----------------------------------------------------------------
  logic methodNeg;
  logic methodHome;
  logic homeDirPos;
  logic targetActive;
  logic [15:0] searchEff;
  logic [15:0] leaveEff;
  assign methodNeg = (method_r == hss_pkg::METHOD_NEG_LIMIT); // RULE13
  assign methodHome = (method_r >= hss_pkg::METHOD_HOME_FIRST) && (method_r <= hss_pkg::METHOD_HOME_LAST); // RULE14
  assign homeDirPos = 1'b0;
  assign targetActive = methodNeg ? negActive : homeActive;
  assign searchEff = (searchSpeed_r > rampSpeedCeiling) ? rampSpeedCeiling : searchSpeed_r; // RULE6
  assign leaveEff = (leaveSpeed_r > rampSpeedCeiling) ? rampSpeedCeiling : leaveSpeed_r; // RULE6

  logic [31:0] anchor_r;
  logic [31:0] travelled;
  logic searchDir;
  logic limitHit;
  assign travelled = absDiff(motorPosition, anchor_r);
  assign searchDir = methodNeg ? 1'b0 : homeDirPos;
  assign limitHit = searchDir ? posActive : negActive;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic failNow;
  logic startGo;
  always_comb begin
    state_nxt = state_r;
    failNow = 1'b0;
    case (state_r)
      hss_pkg::HS_IDLE: begin
        if (start && (methodNeg || methodHome)) begin
          state_nxt = hss_pkg::HS_SEARCH; // RULE10
        end
      end
      hss_pkg::HS_SEARCH: begin
        if (targetActive) begin
          state_nxt = hss_pkg::HS_EDGE; // RULE10
        end else if (methodHome && limitHit) begin
          state_nxt = hss_pkg::HS_OVERRUN; // RULE9
        end
      end
      hss_pkg::HS_OVERRUN: begin
        if (targetActive) begin
          state_nxt = hss_pkg::HS_EDGE;
        end else if (overLimit(overrunLimit_r, travelled)) begin
          failNow = 1'b1; // RULE9
        end
      end
      hss_pkg::HS_EDGE: begin
        if (!targetActive) begin
          state_nxt = hss_pkg::HS_DIST; // RULE10
        end else if (overLimit(edgeLimit_r, travelled)) begin
          failNow = 1'b1; // RULE8
        end
      end
      hss_pkg::HS_DIST: begin
        if (moveDone) begin
          state_nxt = hss_pkg::HS_LOAD;
        end
      end
      hss_pkg::HS_LOAD: begin
        state_nxt = hss_pkg::HS_IDLE;
      end
      default: begin
        state_nxt = hss_pkg::HS_IDLE;
      end
    endcase
    // Halt, power loss or a monitor trip ends the run without a new zero point
    if (state_r != hss_pkg::HS_IDLE && (halt || !powerEnabled || failNow)) begin
      state_nxt = hss_pkg::HS_IDLE; // RULE15 RULE16
    end
  end
  assign startGo = (state_r == hss_pkg::HS_IDLE) && (state_nxt == hss_pkg::HS_SEARCH);

  always_ff @(posedge clk) begin
    if (reset) begin
      state_r <= hss_pkg::HS_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Distance monitors count from the position where each phase began
  always_ff @(posedge clk) begin
    if (reset) begin
      anchor_r <= 32'h0000_0000;
    end else if (state_nxt != state_r) begin
      anchor_r <= motorPosition; // RULE8 RULE9
    end
  end

  // ----------------------------------------------------------------
  // Motion and load outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      motionCmd <= '0;
    end else begin
      motionCmd.move <= (state_nxt == hss_pkg::HS_SEARCH) || (state_nxt == hss_pkg::HS_OVERRUN)
                        || (state_nxt == hss_pkg::HS_EDGE);
      if (state_nxt == hss_pkg::HS_SEARCH) begin
        motionCmd.dirPos <= searchDir;
        motionCmd.speed <= searchEff; // RULE12
      end else begin
        motionCmd.dirPos <= !searchDir;
        motionCmd.speed <= leaveEff; // RULE12
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      distMoveReq <= 1'b0;
      distTarget <= 32'h0000_0000;
      posLoad <= 1'b0;
      posLoadValue <= 32'h0000_0000;
    end else begin
      distMoveReq <= (state_r == hss_pkg::HS_EDGE) && (state_nxt == hss_pkg::HS_DIST); // RULE11
      distTarget <= searchDir ? (motorPosition - edgeDist_r) : (motorPosition + edgeDist_r); // RULE11
      posLoad <= (state_nxt == hss_pkg::HS_LOAD); // RULE7
      posLoadValue <= homePos_r; // RULE7
    end
  end

  // ----------------------------------------------------------------
  // Status
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      busy <= 1'b0;
      modeLock <= 1'b0;
    end else begin
      busy <= (state_nxt != hss_pkg::HS_IDLE);
      modeLock <= (state_nxt != hss_pkg::HS_IDLE); // RULE16
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      done <= 1'b0;
      error <= 1'b0;
    end else if (startGo) begin
      done <= 1'b0;
      error <= 1'b0;
    end else begin
      if (state_r == hss_pkg::HS_LOAD) begin
        done <= 1'b1; // RULE17
      end
      if (state_r != hss_pkg::HS_IDLE && (failNow || !powerEnabled)) begin
        error <= 1'b1; // RULE17
      end
    end
  end

  // Reference survives power stage disable; only a new run drops it
  always_ff @(posedge clk) begin
    if (reset) begin
      refValid <= 1'b0;
    end else if (startGo) begin
      refValid <= 1'b0; // RULE16
    end else if (state_r == hss_pkg::HS_LOAD) begin
      refValid <= 1'b1; // RULE15 RULE16
    end
  end

endmodule : homing_switch_sequencer

//--- dv/hss_axis_model.sv
// Axis model with a switch cam for the reference and negative travel switches; positive travel switch tied high
module hss_axis_model (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Commands from the sequencer
  input wire hss_pkg::hss_motion_t motionCmd,
  input wire logic distMoveReq,
  input wire logic posLoad,
  input wire logic [31:0] posLoadValue,
  // Wiring choice, high for normally closed, and cam edge
  input wire logic ncHome,
  input wire logic ncNeg,
  input wire logic [31:0] switchEdge,
  // Axis outputs
  output logic [31:0] motorPosition,
  output logic moveDone,
  output logic homeSwitchIn,
  output logic negativeTravelSwitch,
  output logic positiveTravelSwitch
);
  // ----------------------------------------------------------------
  // Home and negative switches: actuated below the cam edge, contact opens when closed type
  // ----------------------------------------------------------------
  logic [3:0] moveCnt_r;
  logic inSwitch;
  assign inSwitch = $signed(motorPosition) < $signed(switchEdge);
  assign homeSwitchIn = ncHome ? !inSwitch : inSwitch;
  assign negativeTravelSwitch = ncNeg ? !inSwitch : inSwitch;
  assign positiveTravelSwitch = 1'b1;
  assign moveDone = moveCnt_r == 4'h1;
  always_ff @(posedge clk) begin
    if (reset) begin
      motorPosition <= 32'h0000_0000;
    end else if (posLoad) begin
      motorPosition <= posLoadValue;
    end else if (motionCmd.move) begin
      motorPosition <= motionCmd.dirPos ? motorPosition + 32'h1 : motorPosition - 32'h1;
    end
  end
  // Distance move ends a few cycles after it is requested
  always_ff @(posedge clk) begin
    if (reset) begin
      moveCnt_r <= 4'h0;
    end else if (moveCnt_r != 4'h0) begin
      moveCnt_r <= moveCnt_r - 4'h1;
    end else if (distMoveReq) begin
      moveCnt_r <= 4'h6;
    end
  end
endmodule : hss_axis_model

//--- dv/hss_checker_sva.sv
// Port assertions of the homing sequencer
module hss_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Observed ports
  input wire hss_pkg::hss_reg_req_t regReq,
  input wire hss_pkg::hss_reg_rsp_t regRsp,
  input wire logic [15:0] rampSpeedCeiling,
  input wire logic halt,
  input wire logic powerEnabled,
  input wire hss_pkg::hss_motion_t motionCmd,
  input wire logic posLoad,
  input wire logic [31:0] posLoadValue,
  input wire logic busy,
  input wire logic done,
  input wire logic error,
  input wire logic refValid,
  input wire logic modeLock
);
  // ----------------------------------------------------------------
  // Shadow of the home position value
  // ----------------------------------------------------------------
  logic [31:0] homeVal_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  always_ff @(posedge clk) begin
    if (reset) begin
      homeVal_r <= hss_pkg::HOME_POS_RESET;
    end else if (regReq.wr && regReq.addr == hss_pkg::HOME_POSITION_VALUE_ADDR) begin
      homeVal_r <= regReq.wdata;
    end
  end
  AST_DONE_ERR: assert property (!(done && error)) else $error("done and error together");
  AST_CLAMP: assert property (motionCmd.move |-> motionCmd.speed <= rampSpeedCeiling)
    else $error("speed above ceiling");
  AST_LOAD_VAL: assert property (posLoad |-> posLoadValue == homeVal_r) else $error("wrong home value");
  AST_LOAD_REF: assert property (posLoad |=> refValid) else $error("reference not valid after load");
  AST_ERR_NOLOAD: assert property (error |-> !posLoad) else $error("load on error");
  AST_HALT: assert property (busy && halt |-> ##[1:8] !busy) else $error("halt did not end homing");
  AST_LOCK: assert property (busy |-> modeLock) else $error("mode lock missing while busy");
  AST_KEEP: assert property ($fell(powerEnabled) && refValid |=> refValid)
    else $error("reference lost on disable");
  AST_IDLE: assert property (!busy && $past(!busy) |-> !motionCmd.move) else $error("motion while idle");
  cover property (posLoad);
  cover property (error);
  cover property (busy && halt);
endmodule : hss_checker
bind homing_switch_sequencer hss_checker u_hss_checker (.*);

//--- dv/testbench.sv
// Self-checking testbench of the homing sequencer
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset, start, halt, powerEnabled, ncHome, ncNeg, homeSwitchIn, negativeTravelSwitch;
  logic positiveTravelSwitch, moveDone, distMoveReq, posLoad, busy, done, error, refValid, modeLock;
  logic [15:0] rampSpeedCeiling;
  logic [31:0] motorPosition, distTarget, posLoadValue, switchEdge;
  hss_pkg::hss_reg_req_t regReq;
  hss_pkg::hss_reg_rsp_t regRsp, rsp;
  hss_pkg::hss_motion_t motionCmd, firstMove, backMove;
  int miscompares = 0;
  int check_count = 0;
  int cycles = 0;
  homing_switch_sequencer u_homing_switch_sequencer (.*);
  hss_axis_model u_hss_axis_model (.*);
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      miscompares++;
      $display("CHECK FAILED %0t %s", $time, msg);
    end
  endtask : chk
  task automatic regAcc(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(negedge clk);
    regReq = '{!wr, wr, a, d};
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (regRsp.valid !== 1'b1 && n < 20);
    rsp = regRsp;
    @(negedge clk);
    regReq = '0;
    chk(n < 20, "register access not answered");
  endtask : regAcc
  task automatic wrRead(input logic [15:0] a, input logic [31:0] d, input logic [31:0] e);
    regAcc(1'b1, a, d);
    regAcc(1'b0, a, 32'h0000_0000);
    chk(rsp.rdata === e, "register holds wrong value after write");
  endtask : wrRead
  task automatic homing(input logic [15:0] m, input logic [31:0] ofs, input int haltAt);
    int n;
    regAcc(1'b1, hss_pkg::HOMING_METHOD_SELECT_ADDR, {16'h0000, m});
    switchEdge = motorPosition + ofs;
    firstMove = '0;
    backMove = '0;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    for (n = 0; n < 6000 && done !== 1'b1 && error !== 1'b1 && n < haltAt + 8; n++) begin
      if (n == haltAt) halt = 1'b1;
      if (motionCmd.move === 1'b1 && firstMove.move !== 1'b1) firstMove = motionCmd;
      if (motionCmd.move === 1'b1 && motionCmd.dirPos !== firstMove.dirPos && backMove.move !== 1'b1) backMove = motionCmd;
      @(negedge clk);
    end
    halt = 1'b0;
  endtask : homing
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic tResetValues;
    logic [15:0] a [9] = '{16'h061C, 16'h061E, 16'h0620, 16'h2808, 16'h280A, 16'h280C, 16'h280E, 16'h2816, 16'h281A};
    logic [31:0] e [9] = '{32'h1, 32'h1, 32'h1, 32'h3C, 32'h6, 32'h0, 32'hC8, 32'h0, 32'h0};
    for (int i = 0; i < 9; i++) begin
      regAcc(1'b0, a[i], 32'h0000_0000);
      chk(rsp.rdata === e[i], "reset value wrong");
    end
    regAcc(1'b0, 16'h0100, 32'h0000_0000);
    chk(rsp.err === 1'b1, "unmapped address not refused");
  endtask : tResetValues
  task automatic tRange;
    wrRead(hss_pkg::SWITCH_SEARCH_SPEED_ADDR, 32'h0000_3391, 32'h0000_3390);
    wrRead(hss_pkg::SWITCH_SEARCH_SPEED_ADDR, 32'h0000_0000, 32'h0000_0001);
    wrRead(hss_pkg::SWITCH_SEARCH_SPEED_ADDR, 32'h0000_3390, 32'h0000_3390);
    wrRead(hss_pkg::SWITCH_LEAVE_SPEED_ADDR, 32'h0000_0BB9, 32'h0000_0BB8);
    wrRead(hss_pkg::SWITCH_LEAVE_SPEED_ADDR, 32'h0000_0006, 32'h0000_0006);
    wrRead(hss_pkg::EDGE_TO_HOME_DISTANCE_ADDR, 32'h0000_0000, 32'h0000_00C8);
  endtask : tRange
  task automatic tIdle;
    switchEdge = motorPosition + 32'h0000_0064;
    repeat (5) @(negedge clk);
    chk(busy === 1'b0 && motionCmd.move === 1'b0, "idle switch change started motion");
  endtask : tIdle
  task automatic tMethod17;
    regAcc(1'b1, hss_pkg::HOME_POSITION_VALUE_ADDR, 32'hFFFF_FF9C);
    homing(16'h0011, 32'hFFFF_FFEC, 99999);
    chk(done === 1'b1 && error === 1'b0, "negative limit homing did not finish");
    chk(firstMove.dirPos === 1'b0 && firstMove.speed === 16'h3390, "approach wrong");
    chk(backMove.speed === 16'h0006, "edge return not at leave speed");
    @(negedge clk);
    chk(refValid === 1'b1 && motorPosition === 32'hFFFF_FF9C, "zero point not loaded");
    powerEnabled = 1'b0;
    repeat (3) @(negedge clk);
    chk(refValid === 1'b1, "reference lost on disable");
    powerEnabled = 1'b1;
  endtask : tMethod17
  task automatic tMethod27;
    ncHome = 1'b0;
    regAcc(1'b1, hss_pkg::HOME_SWITCH_POLARITY_ADDR, 32'h0000_0002);
    rampSpeedCeiling = 16'h0028;
    homing(16'h001B, 32'hFFFF_FFEC, 99999);
    chk(done === 1'b1 && firstMove.speed === 16'h0028, "home switch homing wrong");
    rampSpeedCeiling = 16'h3390;
  endtask : tMethod27
  task automatic tEdgeError;
    regAcc(1'b1, hss_pkg::EDGE_SEARCH_LIMIT_ADDR, 32'h0000_0005);
    homing(16'h0011, 32'h0000_03E8, 99999);
    chk(error === 1'b1 && done !== 1'b1, "edge limit not enforced");
    regAcc(1'b1, hss_pkg::EDGE_SEARCH_LIMIT_ADDR, 32'h0000_0000);
  endtask : tEdgeError
  task automatic tHalt;
    homing(16'h0011, 32'hFFFF_FC18, 10);
    chk(busy === 1'b0 && done !== 1'b1, "halt did not end homing");
  endtask : tHalt
  task automatic complete_run;
    if (miscompares == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : complete_run
  // ----------------------------------------------------------------
  // Clock, timeout and main sequence
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      miscompares++;
      complete_run;
    end
  end
  initial begin
    reset = 1'b1;
    start = 1'b0;
    halt = 1'b0;
    powerEnabled = 1'b1;
    ncHome = 1'b1;
    ncNeg = 1'b1;
    regReq = '0;
    rampSpeedCeiling = 16'h3390;
    switchEdge = 32'h8000_0000;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    repeat (2) @(negedge clk);
    tResetValues;
    tRange;
    tIdle;
    tMethod17;
    tMethod27;
    tEdgeError;
    tHalt;
    complete_run;
  end
endmodule : testbench
